// ===== inc/remap_out_pkg.sv
// constants for the remappable output pin select block
package remap_out_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;

  // ----------------------------------------------------------------
  // register offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFFSET_SELECT_PAIR_FOUR = 12'h000;
  localparam logic [11:0] OFFSET_SELECT_PAIR_FIVE = 12'h004;

  // ----------------------------------------------------------------
  // field layout of both select registers
  // ----------------------------------------------------------------
  localparam int unsigned SELECT_W = 6;
  localparam int unsigned SELECT_HIGH_LSB = 8;
  localparam int unsigned SELECT_LOW_LSB = 0;
  localparam int unsigned HIGH_LANE = 1;
  localparam int unsigned LOW_LANE = 0;
  localparam logic [5:0] SELECT_RESET = 6'h00;

  // ----------------------------------------------------------------
  // peripheral output bundle
  // ----------------------------------------------------------------
  localparam int unsigned FUNCTION_COUNT = 64;
  localparam logic [5:0] FUNCTION_NONE = 6'h00;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage : remap_out_pkg

// ===== core/output_function_mux.sv
// one remappable pin: picks a peripheral output by function number
`timescale 1ns/1ps

module output_function_mux
  import remap_out_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // selection and sources
  input wire logic [remap_out_pkg::SELECT_W-1:0] functionSelect,
  input wire logic [remap_out_pkg::FUNCTION_COUNT-1:0] periphOut,
  // pin drive
  output logic pinOut,
  output logic pinDrive
);

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  wire logic routed = (functionSelect != FUNCTION_NONE);
  wire logic picked = periphOut[functionSelect];

  // registered so the pin never sees a decode glitch
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinOut <= 1'b0;
      pinDrive <= 1'b0;
    end else begin
      pinOut <= routed & picked;
      pinDrive <= routed;
    end
  end

endmodule : output_function_mux

// ===== core/remappable_output_pin_select.sv
// output pin remapper for four pins, two select registers on apb
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps

// Behaviour
// - pin a carries the peripheral output numbered by bits 13..8 of pair four.
// - pin b carries the peripheral output numbered by bits 5..0 of pair four.
// - pin c carries the peripheral output numbered by bits 13..8 of pair five.
// - pin d carries the peripheral output numbered by bits 5..0 of pair five.
// - bits 15..14 and 7..6 read zero, writes to them are dropped.
module remappable_output_pin_select
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [remap_out_pkg::ADDR_W-1:0] paddr,
  input wire logic [remap_out_pkg::DATA_W-1:0] pwdata,
  input wire logic [remap_out_pkg::STRB_W-1:0] pstrb,
  output logic [remap_out_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // peripheral output bundle
  input wire logic [remap_out_pkg::FUNCTION_COUNT-1:0] periphOut,
  // remappable pins
  output logic remappablePinA,
  output logic remappablePinAEnable,
  output logic remappablePinB,
  output logic remappablePinBEnable,
  output logic remappablePinC,
  output logic remappablePinCEnable,
  output logic remappablePinD,
  output logic remappablePinDEnable
);
  import remap_out_pkg::*;

  // ----------------------------------------------------------------
  // select fields
  // ----------------------------------------------------------------
  logic [SELECT_W-1:0] pinAFunctionSelect;
  logic [SELECT_W-1:0] pinBFunctionSelect;
  logic [SELECT_W-1:0] pinCFunctionSelect;
  logic [SELECT_W-1:0] pinDFunctionSelect;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic setupPhase = psel & ~penable;
  wire logic accessDone = psel & penable & pready;
  wire logic hitFour = (paddr == OFFSET_SELECT_PAIR_FOUR);
  wire logic hitFive = (paddr == OFFSET_SELECT_PAIR_FIVE);
  wire logic hitAny = hitFour | hitFive;
  wire logic writeFour = accessDone & pwrite & hitFour;
  wire logic writeFive = accessDone & pwrite & hitFive;
  wire logic writeHigh = pstrb[HIGH_LANE];
  wire logic writeLow = pstrb[LOW_LANE];
  // only the six field bits of each lane are taken
  wire logic [SELECT_W-1:0] wrHigh = pwdata[SELECT_HIGH_LSB +: SELECT_W];
  wire logic [SELECT_W-1:0] wrLow = pwdata[SELECT_LOW_LSB +: SELECT_W];

  // read image: unimplemented and upper bits stay zero
  logic [DATA_W-1:0] imageFour;
  logic [DATA_W-1:0] imageFive;
  always_comb begin
    imageFour = READ_ZERO;
    imageFour[SELECT_HIGH_LSB +: SELECT_W] = pinAFunctionSelect;
    imageFour[SELECT_LOW_LSB +: SELECT_W] = pinBFunctionSelect;
    imageFive = READ_ZERO;
    imageFive[SELECT_HIGH_LSB +: SELECT_W] = pinCFunctionSelect;
    imageFive[SELECT_LOW_LSB +: SELECT_W] = pinDFunctionSelect;
  end

  wire logic [DATA_W-1:0] next_prdata = (setupPhase & ~pwrite & hitFour) ? imageFour :
                                        (setupPhase & ~pwrite & hitFive) ? imageFive :
                                        READ_ZERO;
  wire logic next_pready = setupPhase;
  wire logic next_pslverr = setupPhase & ~hitAny;

  // ----------------------------------------------------------------
  // bus answer registers
  // ----------------------------------------------------------------
  // answer prepared in setup, so every access ends after one access cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= READ_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // select registers
  // ----------------------------------------------------------------
  // byte lanes steer the fields; a lane left out keeps its field
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pinAFunctionSelect <= SELECT_RESET;
      pinBFunctionSelect <= SELECT_RESET;
      pinCFunctionSelect <= SELECT_RESET;
      pinDFunctionSelect <= SELECT_RESET;
    end else begin
      if (writeFour & writeHigh) begin
        pinAFunctionSelect <= wrHigh;
      end
      if (writeFour & writeLow) begin
        pinBFunctionSelect <= wrLow;
      end
      if (writeFive & writeHigh) begin
        pinCFunctionSelect <= wrHigh;
      end
      if (writeFive & writeLow) begin
        pinDFunctionSelect <= wrLow;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin routing
  // ----------------------------------------------------------------
  // function zero leaves the pin undriven by the remapper
  output_function_mux muxPinA (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .functionSelect(pinAFunctionSelect),
    .periphOut(periphOut),
    .pinOut(remappablePinA),
    .pinDrive(remappablePinAEnable)
  );

  output_function_mux muxPinB (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .functionSelect(pinBFunctionSelect),
    .periphOut(periphOut),
    .pinOut(remappablePinB),
    .pinDrive(remappablePinBEnable)
  );

  output_function_mux muxPinC (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .functionSelect(pinCFunctionSelect),
    .periphOut(periphOut),
    .pinOut(remappablePinC),
    .pinDrive(remappablePinCEnable)
  );

  output_function_mux muxPinD (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .functionSelect(pinDFunctionSelect),
    .periphOut(periphOut),
    .pinOut(remappablePinD),
    .pinDrive(remappablePinDEnable)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_route_pin_a;
    (pinAFunctionSelect != FUNCTION_NONE)
      |=> remappablePinAEnable && (remappablePinA == $past(periphOut[pinAFunctionSelect]));
  endproperty
  a_route_pin_a: assert property (p_route_pin_a)
    else $error("pin a does not carry its selected function");

  property p_route_pin_b;
    (pinBFunctionSelect != FUNCTION_NONE)
      |=> remappablePinBEnable && (remappablePinB == $past(periphOut[pinBFunctionSelect]));
  endproperty
  a_route_pin_b: assert property (p_route_pin_b)
    else $error("pin b does not carry its selected function");

  property p_route_pin_c;
    (pinCFunctionSelect != FUNCTION_NONE)
      |=> remappablePinCEnable && (remappablePinC == $past(periphOut[pinCFunctionSelect]));
  endproperty
  a_route_pin_c: assert property (p_route_pin_c)
    else $error("pin c does not carry its selected function");

  property p_route_pin_d;
    (pinDFunctionSelect != FUNCTION_NONE)
      |=> remappablePinDEnable && (remappablePinD == $past(periphOut[pinDFunctionSelect]));
  endproperty
  a_route_pin_d: assert property (p_route_pin_d)
    else $error("pin d does not carry its selected function");

  property p_write_four_lands;
    (writeFour && pstrb == 4'hF)
      |=> (imageFour[15:0] == ($past(pwdata[15:0]) & 16'h3F3F)) ##1 remappablePinAEnable
          == (pinAFunctionSelect != FUNCTION_NONE);
  endproperty
  a_write_four_lands: assert property (p_write_four_lands)
    else $error("write to pair four not reflected in fields");

  property p_write_five_lands;
    (writeFive && pstrb == 4'hF)
      |=> (imageFive[15:0] == ($past(pwdata[15:0]) & 16'h3F3F));
  endproperty
  a_write_five_lands: assert property (p_write_five_lands)
    else $error("write to pair five not reflected in fields");

  property p_reserved_read_zero;
    (accessDone && !pwrite) |-> (prdata[31:14] == 18'h0_0000) && (prdata[7:6] == 2'h0);
  endproperty
  a_reserved_read_zero: assert property (p_reserved_read_zero)
    else $error("unimplemented bits read non-zero");

  property p_reset_unrouted;
    $rose(reset_n) |-> !remappablePinAEnable && !remappablePinBEnable
      && !remappablePinCEnable && !remappablePinDEnable && (imageFour == READ_ZERO)
      && (imageFive == READ_ZERO);
  endproperty
  a_reset_unrouted: assert property (p_reset_unrouted)
    else $error("pins routed or fields set right after reset");

  property p_one_wait_answer;
    setupPhase |=> pready ##1 !pready || setupPhase;
  endproperty
  a_one_wait_answer: assert property (p_one_wait_answer)
    else $error("apb answer not in the access cycle");

  property p_unmapped_error;
    (accessDone && !hitAny) |-> pslverr && (prdata == READ_ZERO);
  endproperty
  a_unmapped_error: assert property (p_unmapped_error)
    else $error("unmapped access without error answer");

  // a write that hits no register must leave both images alone
  property p_unmapped_write_dropped;
    (accessDone && pwrite && !hitAny) |=> $stable(imageFour) && $stable(imageFive);
  endproperty
  a_unmapped_write_dropped: assert property (p_unmapped_write_dropped)
    else $error("unmapped write changed a select field");

  // the answer register must stay quiet unless a setup cycle came first
  property p_answer_only_after_setup;
    !setupPhase |=> !pready;
  endproperty
  a_answer_only_after_setup: assert property (p_answer_only_after_setup)
    else $error("apb answer without a setup cycle");

  // function zero must leave the pin released and low
  property p_zero_pin_a;
    (pinAFunctionSelect == FUNCTION_NONE) |=> !remappablePinAEnable && !remappablePinA;
  endproperty
  a_zero_pin_a: assert property (p_zero_pin_a)
    else $error("pin a driven while its select is zero");

  property p_zero_pin_b;
    (pinBFunctionSelect == FUNCTION_NONE) |=> !remappablePinBEnable && !remappablePinB;
  endproperty
  a_zero_pin_b: assert property (p_zero_pin_b)
    else $error("pin b driven while its select is zero");

  property p_zero_pin_c;
    (pinCFunctionSelect == FUNCTION_NONE) |=> !remappablePinCEnable && !remappablePinC;
  endproperty
  a_zero_pin_c: assert property (p_zero_pin_c)
    else $error("pin c driven while its select is zero");

  property p_zero_pin_d;
    (pinDFunctionSelect == FUNCTION_NONE) |=> !remappablePinDEnable && !remappablePinD;
  endproperty
  a_zero_pin_d: assert property (p_zero_pin_d)
    else $error("pin d driven while its select is zero");

  // a lane left out of the strobes must not disturb its field
  property p_keep_pin_a;
    (writeFour && !writeHigh) |=> (pinAFunctionSelect == $past(pinAFunctionSelect));
  endproperty
  a_keep_pin_a: assert property (p_keep_pin_a)
    else $error("pin a field changed by a write without its lane");

  property p_keep_pin_b;
    (writeFour && !writeLow) |=> (pinBFunctionSelect == $past(pinBFunctionSelect));
  endproperty
  a_keep_pin_b: assert property (p_keep_pin_b)
    else $error("pin b field changed by a write without its lane");

  property p_keep_pin_c;
    (writeFive && !writeHigh) |=> (pinCFunctionSelect == $past(pinCFunctionSelect));
  endproperty
  a_keep_pin_c: assert property (p_keep_pin_c)
    else $error("pin c field changed by a write without its lane");

  property p_keep_pin_d;
    (writeFive && !writeLow) |=> (pinDFunctionSelect == $past(pinDFunctionSelect));
  endproperty
  a_keep_pin_d: assert property (p_keep_pin_d)
    else $error("pin d field changed by a write without its lane");

  c_write_four: cover property (writeFour);
  c_read_five: cover property (accessDone && !pwrite && hitFive);
  c_pin_a_routed: cover property (writeFour ##2 remappablePinAEnable);
  c_unmapped: cover property (accessDone && pslverr);

endmodule : remappable_output_pin_select

// ===== bench/periph_output_source.sv
// partner model: the peripheral output bundle feeding the remapper
`timescale 1ns/1ps

module periph_output_source
  import remap_out_pkg::*;
#(
  parameter logic [63:0] START = 64'h9E37_79B9_7F4A_7C15
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // function lines toward the remapper
  output logic [remap_out_pkg::FUNCTION_COUNT-1:0] periphOut
);
  // ----------------------------------------------------------------
  // pattern
  // ----------------------------------------------------------------
  // lfsr rather than a counter, so high and low lines both toggle and a stuck select shows
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      periphOut <= START;
    end else begin
      periphOut <= {periphOut[62:0], periphOut[63] ^ periphOut[62] ^ periphOut[60] ^ periphOut[59]};
    end
  end
endmodule : periph_output_source

// ===== bench/remappable_output_pin_select_tb.sv
// self-checking bench: apb master, select model and pin comparison
`timescale 1ns/1ps

module remappable_output_pin_select_tb;
  import remap_out_pkg::*;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [STRB_W-1:0] pstrb = '0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [FUNCTION_COUNT-1:0] periphOut;
  // nets, since four separate pin ports each drive one bit
  wire [3:0] pinVec;
  wire [3:0] enVec;
  logic [5:0] sel [4] = '{default: 6'h00};
  logic [31:0] rd;
  logic [31:0] seedVal;
  logic err;
  int failCount = 0;
  int checksDone = 0;

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // device and partner
  // ----------------------------------------------------------------
  remappable_output_pin_select DUT (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .periphOut(periphOut),
    .remappablePinA(pinVec[0]), .remappablePinAEnable(enVec[0]),
    .remappablePinB(pinVec[1]), .remappablePinBEnable(enVec[1]),
    .remappablePinC(pinVec[2]), .remappablePinCEnable(enVec[2]),
    .remappablePinD(pinVec[3]), .remappablePinDEnable(enVec[3])
  );

  periph_output_source src (.core_clk(core_clk), .reset_n(reset_n), .periphOut(periphOut));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string name, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask : cmp

  // one apb transfer; waits on pready, no assumed latency
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ok;
    int b;
    ok = (a == OFFSET_SELECT_PAIR_FOUR) || (a == OFFSET_SELECT_PAIR_FIVE);
    b = (a == OFFSET_SELECT_PAIR_FOUR) ? 0 : 2;
    xfer(1'b1, a, d, s);
    cmp("write error", {31'b0, !ok}, {31'b0, err});
    if (ok && s[1]) sel[b] = d[13:8];
    if (ok && s[0]) sel[b + 1] = d[5:0];
  endtask : wr

  task automatic rdchk(input logic [11:0] a);
    logic ok;
    int b;
    ok = (a == OFFSET_SELECT_PAIR_FOUR) || (a == OFFSET_SELECT_PAIR_FIVE);
    b = (a == OFFSET_SELECT_PAIR_FOUR) ? 0 : 2;
    xfer(1'b0, a, '0, '0);
    cmp("read error", {31'b0, !ok}, {31'b0, err});
    cmp("read data", ok ? {18'b0, sel[b], 2'b0, sel[b + 1]} : READ_ZERO, rd);
  endtask : rdchk

  // pins follow the function line sampled at the same edge
  task automatic pins(input int n);
    logic [FUNCTION_COUNT-1:0] snap;
    logic [3:0] expP;
    logic [3:0] expE;
    repeat (n) begin
      @(posedge core_clk);
      snap = periphOut;
      for (int i = 0; i < 4; i++) begin
        expP[i] = (sel[i] != 6'h00) && snap[sel[i]];
        expE[i] = (sel[i] != 6'h00);
      end
      #1;
      cmp("pin level", {28'b0, expP}, {28'b0, pinVec});
      cmp("pin enable", {28'b0, expE}, {28'b0, enVec});
    end
    // back onto the edge, so the next bus request starts right after it
    @(posedge core_clk);
  endtask : pins

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  // reset values, boundary codes, random traffic, unmapped, second reset
  initial begin
    seedVal = $urandom(32'h3dfe1689);
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    rdchk(OFFSET_SELECT_PAIR_FOUR);
    rdchk(OFFSET_SELECT_PAIR_FIVE);
    pins(3);
    wr(OFFSET_SELECT_PAIR_FOUR, 32'hFFFF_C101, 4'hF);
    wr(OFFSET_SELECT_PAIR_FIVE, 32'h0000_3FC0, 4'hF);
    rdchk(OFFSET_SELECT_PAIR_FOUR);
    rdchk(OFFSET_SELECT_PAIR_FIVE);
    pins(4);
    for (int k = 0; k < 40; k++) begin
      wr(($urandom & 1) ? OFFSET_SELECT_PAIR_FIVE : OFFSET_SELECT_PAIR_FOUR, $urandom,
         4'($urandom));
      rdchk(OFFSET_SELECT_PAIR_FOUR);
      rdchk(OFFSET_SELECT_PAIR_FIVE);
      pins(3);
    end
    wr(12'h008, 32'hFFFF_FFFF, 4'hF);
    rdchk(12'h008);
    rdchk(12'h404);
    rdchk(OFFSET_SELECT_PAIR_FOUR);
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (sel[i]) sel[i] = SELECT_RESET;
    rdchk(OFFSET_SELECT_PAIR_FOUR);
    rdchk(OFFSET_SELECT_PAIR_FIVE);
    pins(3);
    print_verdict();
  end

  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #(25 * 20000);
    failCount++;
    print_verdict();
  end
endmodule : remappable_output_pin_select_tb
